// file: verilog/spi_flash_seq_defs.svh
// opcodes, address masks, protection geometry and timing figures of the flash sequencer
// assumes a 125 MHz core clock; included by the top module only
`ifndef SPI_FLASH_SEQ_DEFS_SVH
`define SPI_FLASH_SEQ_DEFS_SVH
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_READ_STATUS 8'h05
`define OPC_POWER_DOWN 8'hB9
`define OPC_WAKE 8'hAB
`define OPC_PAGE_PROG 8'h02
`define OPC_SECTOR_ERASE 8'h20
`define OPC_BLOCK32_ERASE 8'h52
`define OPC_BLOCK64_ERASE 8'hD8
`define OPC_CHIP_ERASE_A 8'hC7
`define OPC_CHIP_ERASE_B 8'h60
`define PAGE_MASK 24'h0000FF
`define SECTOR_MASK 24'h000FFF
`define BLOCK32_MASK 24'h007FFF
`define BLOCK64_MASK 24'h00FFFF
`define CHIP_MASK 24'hFFFFFF
`define ARRAY_SIZE 24'h200000
`define PROT_UNIT 24'h010000
`define PROT_ALL_CODE 3'd6
`define CLK_PERIOD_NS 8
`define WAKE_DELAY_NS 3000
`define WAKE_ID_DELAY_NS 3000
`define PAGE_PROGRAM_TIME_US 1000
`define SECTOR_ERASE_TIME_US 100000
`define BLOCK_ERASE_TIME_US 500000
`define CHIP_ERASE_TIME_US 10000000
`define DEVICE_ID_DEFAULT 8'h5A
`endif

// file: verilog/spi_flash_seq_pkg.sv
// types shared by the flash sequencer and its bench
// assumes nothing of its surroundings
package spi_flash_seq_pkg;
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_BUSY = 2'b01,
    ST_POWER_DOWN = 2'b10,
    ST_WAKING = 2'b11
  } seq_state_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PAGE_PROGRAM = 3'b001,
    OP_SECTOR_ERASE = 3'b010,
    OP_BLOCK32_ERASE = 3'b011,
    OP_BLOCK64_ERASE = 3'b100,
    OP_CHIP_ERASE = 3'b101
  } array_op_t;
endpackage

// file: verilog/spi_flash_seq.sv
// serial flash instruction sequencer: wake, identifier, page program and erases
// assumes an spi host in mode 0 on sclk/csN/si, and an array that executes opStart commands
// Behaviour
// - wake-only byte in power-down resumes normal operation only after wake delay.
// - identifier read takes three dummy bytes, then id out msb first, falling edges.
// - identifier byte repeats while chip select stays low.
// - identifier read from power-down resumes only after identifier wake delay.
// - wake or identifier ignored while busy; running cycle untouched.
// - page program executes only with write enable latch set.
// - only low eight address bits advance; data wraps inside the page.
// - beyond 256 bytes, only the last 256 are programmed.
// - fewer bytes program only addressed bytes; others untouched.
// - page program executes only when chip select rises on a byte boundary.
// - accepted operation starts timed cycle, busy high, latch cleared.
// - status reads still answer during a timed cycle.
// - program or erase into protected area is rejected.
// - sector erase is opcode plus address; whole 4KB sector selected.
// - sector and block erases execute only when chip select rises right after address.
// - 32KB block erase clears the containing block, latch set.
// - 64KB block erase clears the containing block, latch set.
// - either chip erase opcode with latch set erases whole array.
// - chip erase is a lone opcode byte, then timed cycle clears latch.
// - chip erase refused whenever any area is protected.
// - in power-down only the wake instruction is recognised.
// - serial input bits are taken on rising serial clock edges.
`include "spi_flash_seq_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module spi_flash_seq #(
  parameter logic [31:0] PAGE_PROGRAM_CYCLES =
    32'((64'(`PAGE_PROGRAM_TIME_US) * 64'd1000 + 64'(`CLK_PERIOD_NS) - 64'd1)
        / 64'(`CLK_PERIOD_NS)),
  parameter logic [31:0] SECTOR_ERASE_CYCLES =
    32'((64'(`SECTOR_ERASE_TIME_US) * 64'd1000 + 64'(`CLK_PERIOD_NS) - 64'd1)
        / 64'(`CLK_PERIOD_NS)),
  parameter logic [31:0] BLOCK_ERASE_CYCLES =
    32'((64'(`BLOCK_ERASE_TIME_US) * 64'd1000 + 64'(`CLK_PERIOD_NS) - 64'd1)
        / 64'(`CLK_PERIOD_NS)),
  parameter logic [31:0] CHIP_ERASE_CYCLES =
    32'((64'(`CHIP_ERASE_TIME_US) * 64'd1000 + 64'(`CLK_PERIOD_NS) - 64'd1)
        / 64'(`CLK_PERIOD_NS)),
  // arbitrary value
  parameter logic [7:0] DEVICE_ID = `DEVICE_ID_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic csN,
  input wire logic si,
  output logic soOut,
  output logic soOeN,
  input wire logic [2:0] blockProtect,
  output logic busyFlag,
  output logic writeEnableLatch,
  output logic powerDown,
  output logic opStart,
  output spi_flash_seq_pkg::array_op_t opKind,
  output logic [23:0] opAddr,
  input wire logic [7:0] bufIndex,
  output logic [7:0] bufData,
  output logic bufValid
);
  import spi_flash_seq_pkg::*;

  localparam logic [31:0] WAKE_CYCLES =
    32'((`WAKE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [31:0] WAKE_ID_CYCLES =
    32'((`WAKE_ID_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);

  // ****************************************
  // link side, clocked by the serial clock
  // ****************************************
  logic fresh_q;
  logic [2:0] bitCnt_q;
  logic [15:0] byteCnt_q;
  logic [7:0] shift_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q;
  logic [7:0] dataCnt_q;
  logic frameTog_q;
  logic [6:0] statMeta_q;
  logic [6:0] statLink_q;
  logic [7:0] pageBuf_q [0:255];
  logic [255:0] bufMask_q;
  logic soOut_q;
  logic soOeN_q;
  logic [6:0] statusWord;
  seq_state_t state_q;
  logic wel_q;

  // counters restart on the first edge of each selection
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  wire [2:0] curBit = fresh_q ? 3'd0 : bitCnt_q;
  wire [15:0] curByte = fresh_q ? 16'd0 : byteCnt_q;
  wire [7:0] rxByte = {shift_q[6:0], si};
  wire byteDone = (curBit == 3'd7);
  wire [2:0] bitCnt_d = 3'(curBit + 3'd1);
  wire [15:0] byteCnt_d = (byteDone && !(&curByte)) ? 16'(curByte + 16'd1) : curByte;
  wire linkBusy = statLink_q[0];
  wire linkPd = statLink_q[5];
  wire linkWaking = statLink_q[6];
  wire opcDone = byteDone && (curByte == 16'd0);
  wire addrDone = byteDone && (curByte != 16'd0) && (curByte < 16'd4);
  wire ppOpen = opcDone && (rxByte == `OPC_PAGE_PROG) && !linkBusy;
  wire dataDone = byteDone && (curByte >= 16'd4) && (opc_q == `OPC_PAGE_PROG) && !linkBusy;
  // only the low byte advances, wrapping in the page
  wire [7:0] bufWrIdx = 8'(addr_q[7:0] + dataCnt_q);

  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      bitCnt_q <= 3'd0;
      byteCnt_q <= 16'd0;
      shift_q <= 8'h00;
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
      dataCnt_q <= 8'h00;
      frameTog_q <= 1'b0;
      statMeta_q <= 7'h00;
      statLink_q <= 7'h00;
    end else begin
      bitCnt_q <= bitCnt_d;
      byteCnt_q <= byteCnt_d;
      shift_q <= rxByte;
      frameTog_q <= frameTog_q ^ fresh_q;
      statMeta_q <= statusWord;
      statLink_q <= statMeta_q;
      if (opcDone) begin
        opc_q <= rxByte;
      end
      if (addrDone) begin
        addr_q <= {addr_q[15:0], rxByte};
      end
      if (addrDone) begin
        dataCnt_q <= 8'h00;
      end else if (dataDone) begin
        dataCnt_q <= 8'(dataCnt_q + 8'h01);
      end
    end
  end

  // later bytes overwrite earlier ones at the same slot
  always_ff @(posedge sclk) begin
    if (dataDone) begin
      pageBuf_q[bufWrIdx] <= rxByte;
    end
  end

  // only written slots are marked for the array
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      bufMask_q <= '0;
    end else if (ppOpen) begin
      bufMask_q <= '0;
    end else if (dataDone) begin
      bufMask_q[bufWrIdx] <= 1'b1;
    end
  end

  // ****************************************
  // serial output, falling edges
  // ****************************************
  // id follows opcode and three dummy bytes
  wire idPhase = (opc_q == `OPC_WAKE) && (byteCnt_q > 16'd3) && !linkBusy && !linkWaking;
  // status answers during a timed cycle
  wire statPhase = (opc_q == `OPC_READ_STATUS) && (byteCnt_q != 16'd0) && !linkPd
    && !linkWaking;
  wire [7:0] statusByte = {3'b000, statLink_q[4:0]};
  wire [7:0] outByte = idPhase ? DEVICE_ID : statusByte;
  wire [2:0] outSel = 3'(3'd7 - bitCnt_q);

  // bit counter wraps, so the same byte repeats
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      soOut_q <= 1'b0;
      soOeN_q <= 1'b1;
    end else begin
      soOut_q <= outByte[outSel];
      soOeN_q <= !(idPhase || statPhase);
    end
  end

  assign soOut = soOut_q;
  assign soOeN = soOeN_q | csN;

  // ****************************************
  // core side: frame end detection
  // ****************************************
  logic [2:0] csSync_q;
  logic csFilt_q;
  logic [2:0] togSync_q;
  logic seen_q;
  wire csRise = csSync_q[1] && csSync_q[2] && !csFilt_q;
  wire togEdge = togSync_q[1] ^ togSync_q[2];

  // pin input: three stages, change taken once second and third agree
  always_ff @(posedge clk) begin
    if (reset) begin
      csSync_q <= 3'b111;
      csFilt_q <= 1'b1;
      togSync_q <= 3'b000;
      seen_q <= 1'b0;
    end else begin
      csSync_q <= {csSync_q[1:0], csN};
      if (csSync_q[1] == csSync_q[2]) begin
        csFilt_q <= csSync_q[2];
      end
      togSync_q <= {togSync_q[1:0], frameTog_q};
      seen_q <= togEdge | (seen_q & ~csRise);
    end
  end

  // link registers are quiet here: the serial clock has stopped with chip select high
  wire frameEnd = csRise && seen_q;
  wire boundary = (bitCnt_q == 3'd0);
  wire oneByte = boundary && (byteCnt_q == 16'd1);
  wire fourBytes = boundary && (byteCnt_q == 16'd4);
  wire idLen = (byteCnt_q > 16'd3);

  // ****************************************
  // decode and protection
  // ****************************************
  wire isChip = (opc_q == `OPC_CHIP_ERASE_A) || (opc_q == `OPC_CHIP_ERASE_B);
  array_op_t opcKind;
  logic [23:0] kindMask;
  logic [31:0] opDur;
  assign opcKind = (opc_q == `OPC_PAGE_PROG) ? OP_PAGE_PROGRAM :
                   (opc_q == `OPC_SECTOR_ERASE) ? OP_SECTOR_ERASE :
                   (opc_q == `OPC_BLOCK32_ERASE) ? OP_BLOCK32_ERASE :
                   (opc_q == `OPC_BLOCK64_ERASE) ? OP_BLOCK64_ERASE :
                   isChip ? OP_CHIP_ERASE : OP_NONE;
  // any address selects its whole page, sector, block or array, by opcode
  assign kindMask = (opcKind == OP_PAGE_PROGRAM) ? `PAGE_MASK :
                    (opcKind == OP_SECTOR_ERASE) ? `SECTOR_MASK :
                    (opcKind == OP_BLOCK32_ERASE) ? `BLOCK32_MASK :
                    (opcKind == OP_BLOCK64_ERASE) ? `BLOCK64_MASK : `CHIP_MASK;
  assign opDur = (opcKind == OP_PAGE_PROGRAM) ? PAGE_PROGRAM_CYCLES :
                 (opcKind == OP_SECTOR_ERASE) ? SECTOR_ERASE_CYCLES :
                 (opcKind == OP_CHIP_ERASE) ? CHIP_ERASE_CYCLES : BLOCK_ERASE_CYCLES;

  // protected area grows down from the top of the array
  wire [23:0] protSize = (blockProtect >= `PROT_ALL_CODE) ? `ARRAY_SIZE :
    (`PROT_UNIT << (blockProtect - 3'd1));
  wire [23:0] protStart = 24'(`ARRAY_SIZE - protSize);
  wire [23:0] targetEnd = addr_q | kindMask;
  // reject targets reaching the protected area
  // chip target spans all, so any protection refuses it
  wire protHit = (blockProtect != 3'd0) && (targetEnd >= protStart);
  // page program needs a byte boundary after data
  // sector and block erases need exactly opcode plus three address bytes
  // chip erase is a lone opcode byte
  wire lenOk = (opcKind == OP_PAGE_PROGRAM) ? (boundary && (byteCnt_q > 16'd4)) :
               (opcKind == OP_CHIP_ERASE) ? oneByte : fourBytes;
  // chip erase opcodes accepted with latch set
  wire accept = (opcKind != OP_NONE) && wel_q && lenOk && !protHit;

  // ****************************************
  // sequencer state
  // ****************************************
  seq_state_t state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic wel_d;
  logic start_d;
  logic opStart_q;
  array_op_t opKind_q;
  logic [23:0] opAddr_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wel_d = wel_q;
    start_d = 1'b0;
    unique case (state_q)
      ST_NORMAL: begin
        // start timed cycle, latch cleared at its start
        if (frameEnd && accept) begin
          state_d = ST_BUSY;
          cnt_d = opDur;
          wel_d = 1'b0;
          start_d = 1'b1;
        end else if (frameEnd && oneByte && (opc_q == `OPC_POWER_DOWN)) begin
          state_d = ST_POWER_DOWN;
        end else if (frameEnd && oneByte && (opc_q == `OPC_WRITE_ENABLE)) begin
          wel_d = 1'b1;
        end else if (frameEnd && oneByte && (opc_q == `OPC_WRITE_DISABLE)) begin
          wel_d = 1'b0;
        end
      end
      ST_BUSY: begin
        cnt_d = cnt_q - 32'd1;
        if (cnt_q == 32'd1) begin
          state_d = ST_NORMAL;
        end
      end
      // only the wake opcode leaves power-down
      ST_POWER_DOWN: begin
        if (frameEnd && (opc_q == `OPC_WAKE) && (oneByte || idLen)) begin
          state_d = ST_WAKING;
          // identifier read uses its own delay
          cnt_d = oneByte ? WAKE_CYCLES : WAKE_ID_CYCLES;
        end
      end
      // nothing accepted until the delay runs out
      ST_WAKING: begin
        cnt_d = cnt_q - 32'd1;
        if (cnt_q == 32'd1) begin
          state_d = ST_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_NORMAL;
      cnt_q <= 32'd0;
      wel_q <= 1'b0;
      opStart_q <= 1'b0;
      opKind_q <= OP_NONE;
      opAddr_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wel_q <= wel_d;
      opStart_q <= start_d;
      if (start_d) begin
        opKind_q <= opcKind;
        opAddr_q <= addr_q & ~kindMask;
      end
    end
  end

  assign statusWord = {state_q == ST_WAKING, state_q == ST_POWER_DOWN, blockProtect,
    wel_q, state_q == ST_BUSY};
  assign busyFlag = (state_q == ST_BUSY);
  assign writeEnableLatch = wel_q;
  assign powerDown = (state_q == ST_POWER_DOWN) || (state_q == ST_WAKING);
  assign opStart = opStart_q;
  assign opKind = opKind_q;
  assign opAddr = opAddr_q;
  // page buffer is only frozen while the program cycle runs
  wire bufOpen = busyFlag && (opKind_q == OP_PAGE_PROGRAM);
  assign bufValid = bufOpen && bufMask_q[bufIndex];
  assign bufData = bufValid ? pageBuf_q[bufIndex] : 8'h00;

  // ****************************************
  // checks
  // ****************************************
  logic [31:0] elapsed_q;
  logic [31:0] target_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      elapsed_q <= 32'd0;
      target_q <= 32'd0;
    end else if (state_d != state_q) begin
      elapsed_q <= 32'd0;
      target_q <= cnt_d;
    end else begin
      elapsed_q <= 32'(elapsed_q + 32'd1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_frame_taken;
    frameEnd ##1 opStart;
  endsequence
  sequence s_cycle_open;
    busyFlag && !writeEnableLatch;
  endsequence

  a_start_sets_busy: assert property (s_frame_taken |-> s_cycle_open)
    else $error("busy or latch wrong at cycle start");
  a_busy_length: assert property ($fell(busyFlag) |-> $past(elapsed_q) == $past(target_q) - 32'd1)
    else $error("timed cycle length wrong");
  a_start_needs_wel: assert property (opStart |-> $past(wel_q) && $past(state_q) == ST_NORMAL)
    else $error("operation started without latch");
  a_protect_reject: assert property (opStart |-> !$past(protHit))
    else $error("protected target started");
  a_chip_unprot: assert property (opStart && opKind == OP_CHIP_ERASE |-> $past(blockProtect) == 3'd0)
    else $error("chip erase with protection");
  a_pp_boundary: assert property (opStart && opKind == OP_PAGE_PROGRAM
    |-> $past(bitCnt_q) == 3'd0 && $past(byteCnt_q) > 16'd4)
    else $error("page program off byte boundary");
  a_erase_exact: assert property (opStart && opKind != OP_PAGE_PROGRAM && opKind != OP_CHIP_ERASE
    |-> $past(byteCnt_q) == 16'd4 && $past(bitCnt_q) == 3'd0)
    else $error("erase with wrong length");
  a_sector_align: assert property (opStart && opKind == OP_SECTOR_ERASE |-> opAddr[11:0] == 12'h000)
    else $error("sector address not aligned");
  a_pd_holds: assert property (state_q == ST_POWER_DOWN && frameEnd && opc_q != `OPC_WAKE
    |=> state_q == ST_POWER_DOWN)
    else $error("power-down left on wrong opcode");
  a_wake_length: assert property ($fell(state_q == ST_WAKING)
    |-> $past(elapsed_q) == $past(target_q) - 32'd1 && state_q == ST_NORMAL)
    else $error("wake delay length wrong");
  a_busy_ignores: assert property (busyFlag && frameEnd |=> !powerDown)
    else $error("frame acted on while busy");
endmodule
`default_nettype wire

// file: sim/spi_host_model.sv
// host spi controller model, mode 0: drives sclk, csN and si, samples so
// assumes the bench fills txBuf and rxFrom before each call of frame
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  output logic sclk,
  output logic csN,
  output logic si,
  input wire logic soOut,
  input wire logic soOeN
);
  logic [7:0] txBuf [0:299];
  logic [7:0] rxByte;
  logic drove;
  logic lastSo;
  int rxFrom;
  event rxDone;

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    lastSo = 1'b0;
    drove = 1'b0;
    rxFrom = 999;
  end

  // ****
  // one frame; extra bits leave it off a byte boundary
  // ****
  // whole frame in one selection
  task automatic frame(input int n, input int extra);
    int i;
    logic b;
    logic [7:0] acc;
    csN = 1'b0;
    drove = 1'b0;
    acc = 8'h00;
    for (i = 0; i < n * 8 + extra; i++) begin
      // msb first, set while sclk low
      si = txBuf[i / 8][7 - i % 8];
      #6;
      sclk = 1'b1;
      // an undriven so line reads as the inverse of its last level
      b = soOeN ? ~lastSo : soOut;
      if (soOeN === 1'b0) begin
        drove = 1'b1;
        lastSo = soOut;
      end
      acc = {acc[6:0], b};
      #6;
      sclk = 1'b0;
      if (i % 8 == 7 && i / 8 >= rxFrom) begin
        rxByte = acc;
        -> rxDone;
      end
    end
    #6;
    csN = 1'b1;
    si = ~si;
    // deselect gap long enough for the core to see the rise
    #60;
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// bench of the flash sequencer: frames from a host model, noted results checked by monitors
// assumes package, design and host model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb;
  import spi_flash_seq_pkg::*;
  typedef struct {array_op_t kind; logic [23:0] addr; int len;} op_note_t;
  localparam int PP_CYC = 80;
  localparam int SE_CYC = 150;
  localparam int BE_CYC = 60;
  localparam int CE_CYC = 90;
  // arbitrary value
  localparam logic [7:0] ID_VAL = 8'hC3;
  localparam logic [7:0] E_OP [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  localparam logic [23:0] E_MASK [5] = '{24'h000FFF, 24'h007FFF, 24'h00FFFF,
    24'hFFFFFF, 24'hFFFFFF};
  localparam array_op_t E_KIND [5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE,
    OP_BLOCK64_ERASE, OP_CHIP_ERASE, OP_CHIP_ERASE};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] blockProtect = 3'h0;
  logic [7:0] bufIndex = 8'h00;
  wire logic sclk, csN, si, soOut, soOeN, busyFlag;
  wire logic writeEnableLatch, powerDown, opStart, bufValid;
  array_op_t opKind;
  logic [23:0] opAddr;
  logic [7:0] bufData;
  int fail_count = 0;
  int tests_run = 0;
  op_note_t opQ[$];
  logic [7:0] byteQ[$];
  op_note_t cur;
  int busyCnt = 0;
  logic counting = 1'b0;
  logic [23:0] a;
  int k;

  always #4 clk = ~clk;

  spi_flash_seq #(.PAGE_PROGRAM_CYCLES(32'(PP_CYC)), .SECTOR_ERASE_CYCLES(32'(SE_CYC)),
    .BLOCK_ERASE_CYCLES(32'(BE_CYC)), .CHIP_ERASE_CYCLES(32'(CE_CYC)), .DEVICE_ID(ID_VAL))
  uut (.clk(clk), .reset(reset), .sclk(sclk), .csN(csN), .si(si), .soOut(soOut),
    .soOeN(soOeN), .blockProtect(blockProtect), .busyFlag(busyFlag),
    .writeEnableLatch(writeEnableLatch), .powerDown(powerDown), .opStart(opStart),
    .opKind(opKind), .opAddr(opAddr), .bufIndex(bufIndex), .bufData(bufData),
    .bufValid(bufValid));

  spi_host_model host (.sclk(sclk), .csN(csN), .si(si), .soOut(soOut), .soOeN(soOeN));

  // ****
  // checks and monitors
  // ****
  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_val({23'h0, got}, {23'h0, exp});
  endtask

  task automatic give_verdict();
    if (opQ.size() != 0 || byteQ.size() != 0) fail_count++;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (reset === 1'b0 && opStart === 1'b1) begin
      if (opQ.size() == 0) begin
        check_flag(opStart, 1'b0);
      end else begin
        cur = opQ.pop_front();
        check_val(24'(opKind), 24'(cur.kind));
        check_val(opAddr, cur.addr);
        counting <= 1'b1;
        busyCnt <= 0;
      end
    end else if (counting) begin
      if (busyFlag === 1'b1) begin
        busyCnt <= busyCnt + 1;
      end else begin
        counting <= 1'b0;
        check_flag(1'(busyCnt >= cur.len - 2 && busyCnt <= cur.len + 2), 1'b1);
      end
    end
  end

  always @(host.rxDone) begin
    if (byteQ.size() == 0) check_flag(1'b1, 1'b0);
    else check_val(24'(host.rxByte), 24'(byteQ.pop_front()));
  end

  task automatic load(input logic [7:0] op, input logic [23:0] ad);
    host.txBuf[0] = op;
    host.txBuf[1] = ad[23:16];
    host.txBuf[2] = ad[15:8];
    host.txBuf[3] = ad[7:0];
  endtask

  task automatic run(input int n, input int extra);
    @(posedge clk);
    #1;
    host.frame(n, extra);
  endtask

  task automatic cmd(input logic [7:0] op);
    host.txBuf[0] = op;
    run(1, 0);
  endtask

  task automatic expect_op(input array_op_t kd, input logic [23:0] ad, input int len);
    op_note_t n;
    n.kind = kd;
    n.addr = ad;
    n.len = len;
    opQ.push_back(n);
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 400 && (busyFlag !== 1'b0 || opQ.size() != 0 || counting); i++) begin
      @(posedge clk);
    end
    if (i == 400) begin
      fail_count++;
      give_verdict();
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic check_slot(input logic [7:0] idx, input logic v, input logic [7:0] d);
    @(posedge clk);
    #1 bufIndex = idx;
    #2;
    check_flag(bufValid, v);
    if (v) check_val(24'(bufData), 24'(d));
  endtask

  task automatic check_wake();
    int i;
    // chip select stays high through the wake delay
    repeat (330) @(posedge clk);
    check_flag(powerDown, 1'b1);
    for (i = 0; i < 100 && powerDown !== 1'b0; i++) @(posedge clk);
    check_flag(powerDown, 1'b0);
    if (i == 100) give_verdict();
  endtask

  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(50));
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    check_flag(busyFlag, 1'b0);
    check_flag(soOeN, 1'b1);
    cmd(8'h06);
    check_flag(writeEnableLatch, 1'b1);
    a = {3'h0, 13'($urandom), 8'hFE};
    load(8'h02, a);
    for (k = 4; k < 7; k++) host.txBuf[k] = 8'($urandom);
    expect_op(OP_PAGE_PROGRAM, {a[23:8], 8'h00}, PP_CYC);
    run(7, 0);
    check_flag(writeEnableLatch, 1'b0);
    check_slot(8'hFE, 1'b1, host.txBuf[4]);
    check_slot(8'h00, 1'b1, host.txBuf[6]);
    check_slot(8'h01, 1'b0, 8'h00);
    wait_idle();
    cmd(8'h06);
    a = {3'h0, 13'($urandom), 8'h00};
    load(8'h02, a);
    for (k = 4; k < 262; k++) host.txBuf[k] = 8'($urandom);
    expect_op(OP_PAGE_PROGRAM, a, PP_CYC);
    run(262, 0);
    host.txBuf[0] = 8'h05;
    host.rxFrom = 1;
    byteQ.push_back(8'h01);
    run(2, 0);
    host.rxFrom = 999;
    check_slot(8'h00, 1'b1, host.txBuf[260]);
    check_slot(8'h02, 1'b1, host.txBuf[6]);
    wait_idle();
    cmd(8'h04);
    load(8'h02, a);
    run(5, 0);
    for (k = 0; k < 3; k++) begin
      cmd(8'h06);
      load(k == 0 ? 8'h02 : k == 1 ? 8'h20 : 8'hC7, a);
      run(k == 0 ? 5 : k == 1 ? 4 : 1, k == 0 ? 5 : k == 1 ? 3 : 1);
    end
    repeat (10) @(posedge clk);
    check_flag(busyFlag, 1'b0);
    for (k = 0; k < 5; k++) begin
      a = {3'h0, 21'($urandom)};
      cmd(8'h06);
      load(E_OP[k], a);
      expect_op(E_KIND[k], a & ~E_MASK[k], k == 0 ? SE_CYC : k < 3 ? BE_CYC : CE_CYC);
      run(k < 3 ? 4 : 1, 0);
      if (k == 0) begin
        host.txBuf[0] = 8'hAB;
        run(5, 0);
        check_flag(host.drove, 1'b0);
        check_flag(busyFlag, 1'b1);
      end
      wait_idle();
    end
    @(posedge clk);
    #1 blockProtect = 3'h1;
    cmd(8'h06);
    load(8'h20, {12'h1F0, 12'($urandom)});
    run(4, 0);
    load(8'h02, 24'h1FFF00);
    run(5, 0);
    cmd(8'hC7);
    repeat (10) @(posedge clk);
    check_flag(busyFlag, 1'b0);
    load(8'h20, 24'h1E5678);
    expect_op(OP_SECTOR_ERASE, 24'h1E5000, SE_CYC);
    run(4, 0);
    wait_idle();
    host.txBuf[0] = 8'hAB;
    host.rxFrom = 4;
    byteQ.push_back(ID_VAL);
    byteQ.push_back(ID_VAL);
    run(6, 0);
    cmd(8'hB9);
    check_flag(powerDown, 1'b1);
    host.rxFrom = 999;
    host.txBuf[0] = 8'h05;
    run(2, 0);
    check_flag(host.drove, 1'b0);
    cmd(8'h06);
    check_flag(writeEnableLatch, 1'b0);
    cmd(8'hAB);
    check_wake();
    cmd(8'hB9);
    host.txBuf[0] = 8'hAB;
    host.rxFrom = 4;
    byteQ.push_back(ID_VAL);
    run(5, 0);
    check_wake();
    cmd(8'h06);
    check_flag(writeEnableLatch, 1'b1);
    give_verdict();
  end

  initial begin
    #700000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
